// ---- core/fault_status_consts.vh ----
// Purpose: constants of the fault status and write protect register bank
// Assumes: byte addressed register port, 32 bit data, four fault inputs
// Notes:   included by every file of the bank but the fault pin source
// Function
// RULE1 - protect enable reads as inverse of disable
// RULE2 - write 1 sets protect, 0 ignored
// RULE3 - clear protect: read 1, then write disable
// RULE4 - protected fields ignore writes while protected
// RULE5 - bit 5 shows OR of enabled inputs
// RULE6 - bit 4 reserved, reads zero
// RULE7 - flag set on enabled detected fault
// RULE8 - flag clears by read then write 0
// RULE9 - writing 1 to flag does nothing
// RULE10 - clearing summary clears every per-input flag
// RULE11 - new fault restarts the clearing sequence
// RULE12 - flag reads 1 after fault, else 0
// RULE13 - summary bit 7 is OR of flags
// RULE14 - protected fields written only when disable set
`ifndef FAULT_STATUS_CONSTS_VH
`define FAULT_STATUS_CONSTS_VH

// register offsets
`define OFS_STATUS      8'h00
`define OFS_MODE        8'h04
`define OFS_FCTRL       8'h08
`define OFS_IRQ_STAT    8'h0C
`define OFS_IRQ_MASK    8'h10

// status register fields
`define ST_SUMMARY      7
`define ST_WP_ON        6
`define ST_IN_OR        5
`define ST_RSVD         4
`define ST_FLAG_HI      3
`define ST_FLAG_LO      0

// mode register fields
`define MD_WP_OFF       2
`define MD_FCTL_EN      0

// fault control register fields
`define FC_FVAL_HI      11
`define FC_FVAL_LO      8
`define FC_FLT_HI       7
`define FC_FLT_LO       4
`define FC_EN_HI        3
`define FC_EN_LO        0

// reset values
`define RST_WP_ON       1'b1
`define RST_FLAGS       4'h0
`define RST_FCTRL       12'h000
`define RST_DATA        32'h0000_0000
`define RST_FVAL        4'h0
`define ZERO_BIT        1'b0
`define ONE_BIT         1'b1

`endif

// ---- core/fault_input_cond.v ----
// Purpose: synchronise one fault pin and optionally filter it
// Assumes: pin is asynchronous to clk
// Notes:   output follows the pin once stable for filter_val cycles
`timescale 1ns/1ps
`include "fault_status_consts.vh"

module fault_input_cond #(
    parameter FW = 4
) (
    // clock and reset
    input  wire          clk,
    input  wire          rst_b,
    // fault pin
    input  wire          pin,
    // filter control
    input  wire          filter_on,
    input  wire [FW-1:0] filter_val,
    // conditioned level
    output reg           level
);

    reg          sync_a;
    reg          sync_b;
    reg [FW-1:0] count;
    reg          use_filter;

    ////////////////////////////////////////////////////////////////////////////
    // two flop synchroniser
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sync_a <= `ZERO_BIT;
            sync_b <= `ZERO_BIT;
        end else begin
            sync_a <= pin;
            sync_b <= sync_a;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // stability filter
    always @* begin
        use_filter = filter_on && (filter_val != {FW{1'b0}});
    end

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            count <= {FW{1'b0}};
            level <= `ZERO_BIT;
        end else if (!use_filter || sync_b == level) begin
            count <= {FW{1'b0}};
            level <= sync_b;
        end else if (count >= filter_val - {{(FW-1){1'b0}}, 1'b1}) begin
            count <= {FW{1'b0}};
            level <= sync_b;
        end else begin
            count <= count + {{(FW-1){1'b0}}, 1'b1};
        end
    end

endmodule

// ---- core/fault_status_protect.v ----
// Purpose: fault status flags, fault input OR and write protection
// Assumes: plain register port, read data one cycle after read strobe
// Notes:   flags clear only by read then write 0 with no fault present
`timescale 1ns/1ps
`include "fault_status_consts.vh"

module fault_status_protect #(
    parameter NF = 4,
    parameter FW = 4
) (
    // clock and reset
    input  wire          clk,
    input  wire          rst_b,
    // register port
    input  wire [7:0]    addr,
    input  wire [31:0]   wdata,
    input  wire          wr,
    input  wire          rd,
    output reg  [31:0]   rdata,
    // fault pins
    input  wire [NF-1:0] fault_pin,
    // status outputs
    output reg           write_protect_on,
    output reg           fault_summary_flag,
    output reg           irq
);

    ////////////////////////////////////////////////////////////////////////////
    // declarations
    reg  [NF-1:0] per_input_fault_flag;
    reg  [NF-1:0] next_flag;
    reg  [NF-1:0] armed;
    reg  [NF-1:0] next_armed;
    reg           armed_sum;
    reg           next_armed_sum;
    reg  [NF-1:0] det_prev;
    reg           fault_ctl_en;
    reg  [NF-1:0] input_en;
    reg  [NF-1:0] filter_en;
    reg  [FW-1:0] filter_val;
    reg           wp_armed;
    reg           next_wp_on;
    reg           next_wp_armed;
    reg  [NF-1:0] irq_stat;
    reg  [NF-1:0] irq_mask;
    reg  [NF-1:0] next_irq_stat;
    reg  [31:0]   next_rdata;
    reg  [31:0]   status_word;
    reg           fault_inputs_or;
    reg           clr_all;
    wire [NF-1:0] cond;
    wire [NF-1:0] det;
    wire [NF-1:0] new_det;
    wire          wr_status;
    wire          rd_status;
    wire          wr_mode;
    wire          wr_fctrl;
    wire          rd_irq;
    wire          wr_mask;
    wire          wp_set;
    wire          wp_clear;
    wire [NF-1:0] flag_rise;
    wire [NF-1:0] clr_bit;
    wire [NF-1:0] mask_now;
    wire [NF-1:0] irq_pend;
    reg  [31:0]   mode_word;
    reg  [31:0]   fctrl_word;

    ////////////////////////////////////////////////////////////////////////////
    // address decode
    assign wr_status = wr && (addr == `OFS_STATUS);
    assign rd_status = rd && (addr == `OFS_STATUS);
    assign wr_mode   = wr && (addr == `OFS_MODE);
    assign wr_fctrl  = wr && (addr == `OFS_FCTRL);
    assign rd_irq    = rd && (addr == `OFS_IRQ_STAT);
    assign wr_mask   = wr && (addr == `OFS_IRQ_MASK);

    ////////////////////////////////////////////////////////////////////////////
    // input conditioning and detection
    genvar j;
    generate
        for (j = 0; j < NF; j = j + 1) begin : g_in
            fault_input_cond #(
                .FW (FW)
            ) u_cond (
                .clk        (clk),
                .rst_b      (rst_b),
                .pin        (fault_pin[j]),
                .filter_on  (filter_en[j]),
                .filter_val (filter_val),
                .level      (cond[j])
            );
        end
    endgenerate

    assign det     = {NF{fault_ctl_en}} & input_en & cond;
    assign new_det = det & ~det_prev;

    always @* begin
        fault_inputs_or = fault_ctl_en && (|(input_en & cond)); // RULE5
    end

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            det_prev <= `RST_FLAGS;
        end else begin
            det_prev <= det;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // write protection
    assign wp_set   = wr_status && wdata[`ST_WP_ON];
    assign wp_clear = wr_mode && wdata[`MD_WP_OFF] && wp_armed;

    always @* begin
        next_wp_on    = write_protect_on;
        next_wp_armed = wp_armed;
        if (rd_status && write_protect_on) begin
            next_wp_armed = `ONE_BIT;
        end
        if (wp_set) begin
            next_wp_on    = `ONE_BIT; // RULE2
            next_wp_armed = `ZERO_BIT;
        end else if (wr_mode) begin
            if (wp_clear) begin
                next_wp_on = `ZERO_BIT; // RULE3
            end
            next_wp_armed = `ZERO_BIT;
        end else if (wr) begin
            next_wp_armed = `ZERO_BIT;
        end
    end

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            write_protect_on <= `RST_WP_ON;
            wp_armed         <= `ZERO_BIT;
        end else begin
            write_protect_on <= next_wp_on;
            wp_armed         <= next_wp_armed;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // mode and fault control registers
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            fault_ctl_en <= `ZERO_BIT;
            input_en     <= `RST_FLAGS;
            filter_en    <= `RST_FLAGS;
            filter_val   <= `RST_FVAL;
        end else begin
            if (wr_mode) begin
                fault_ctl_en <= wdata[`MD_FCTL_EN];
            end
            if (wr_fctrl) begin
                input_en   <= wdata[`FC_EN_HI:`FC_EN_LO];
                filter_val <= wdata[`FC_FVAL_HI:`FC_FVAL_LO];
                if (!write_protect_on) begin
                    filter_en <= wdata[`FC_FLT_HI:`FC_FLT_LO]; // RULE4 RULE14
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // fault flags and clearing sequences
    always @* begin
        clr_all = wr_status && !wdata[`ST_SUMMARY] && armed_sum && !(|det);
    end

    assign clr_bit = {NF{wr_status}} & ~wdata[NF-1:0] & armed; // RULE8

    always @* begin
        next_armed_sum = armed_sum;
        if (|new_det) begin
            next_armed_sum = `ZERO_BIT; // RULE11
        end else if (rd_status && fault_summary_flag) begin
            next_armed_sum = `ONE_BIT;
        end else if (wr_status) begin
            next_armed_sum = `ZERO_BIT;
        end
    end

    generate
        for (j = 0; j < NF; j = j + 1) begin : g_flag
            always @* begin
                next_flag[j]  = per_input_fault_flag[j];
                next_armed[j] = armed[j];
                if (new_det[j]) begin
                    next_armed[j] = `ZERO_BIT; // RULE11
                end else if (rd_status && per_input_fault_flag[j]) begin
                    next_armed[j] = `ONE_BIT; // RULE8
                end else if (wr_status) begin
                    next_armed[j] = `ZERO_BIT;
                end
                if (det[j]) begin
                    next_flag[j] = `ONE_BIT; // RULE7 RULE12
                end else if (clr_all) begin
                    next_flag[j] = `ZERO_BIT; // RULE10
                end else if (clr_bit[j]) begin
                    next_flag[j] = `ZERO_BIT; // RULE8 RULE9
                end
            end
        end
    endgenerate

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            per_input_fault_flag <= `RST_FLAGS;
            armed                <= `RST_FLAGS;
            armed_sum            <= `ZERO_BIT;
            fault_summary_flag   <= `ZERO_BIT;
        end else begin
            per_input_fault_flag <= next_flag;
            armed                <= next_armed;
            armed_sum            <= next_armed_sum;
            fault_summary_flag   <= |next_flag; // RULE13
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt status and mask
    assign flag_rise = det & ~per_input_fault_flag;
    assign mask_now  = wr_mask ? wdata[NF-1:0] : irq_mask;
    assign irq_pend  = next_irq_stat & mask_now;

    always @* begin
        next_irq_stat = rd_irq ? `RST_FLAGS : irq_stat;
        next_irq_stat = next_irq_stat | flag_rise;
    end

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_stat <= `RST_FLAGS;
            irq_mask <= `RST_FLAGS;
            irq      <= `ZERO_BIT;
        end else begin
            irq_stat <= next_irq_stat;
            if (wr_mask) begin
                irq_mask <= wdata[NF-1:0];
            end
            irq <= |irq_pend;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read data
    always @* begin
        status_word                          = `RST_DATA;
        status_word[`ST_SUMMARY]             = |per_input_fault_flag; // RULE13
        status_word[`ST_WP_ON]               = write_protect_on;
        status_word[`ST_IN_OR]               = fault_inputs_or; // RULE5
        status_word[`ST_RSVD]                = `ZERO_BIT; // RULE6
        status_word[`ST_FLAG_HI:`ST_FLAG_LO] = per_input_fault_flag; // RULE12
    end

    always @* begin
        mode_word              = `RST_DATA;
        mode_word[`MD_WP_OFF]  = ~write_protect_on; // RULE1
        mode_word[`MD_FCTL_EN] = fault_ctl_en;
    end

    always @* begin
        fctrl_word                          = `RST_DATA;
        fctrl_word[`FC_FVAL_HI:`FC_FVAL_LO] = filter_val;
        fctrl_word[`FC_FLT_HI:`FC_FLT_LO]   = filter_en;
        fctrl_word[`FC_EN_HI:`FC_EN_LO]     = input_en;
    end

    always @* begin
        next_rdata = `RST_DATA;
        case (addr)
            `OFS_STATUS: begin
                next_rdata = status_word;
            end
            `OFS_MODE: begin
                next_rdata = mode_word;
            end
            `OFS_FCTRL: begin
                next_rdata = fctrl_word;
            end
            `OFS_IRQ_STAT: begin
                next_rdata[NF-1:0] = irq_stat;
            end
            `OFS_IRQ_MASK: begin
                next_rdata[NF-1:0] = irq_mask;
            end
            default: begin
                next_rdata = `RST_DATA;
            end
        endcase
    end

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata <= `RST_DATA;
        end else if (rd) begin
            rdata <= next_rdata;
        end else begin
            rdata <= `RST_DATA;
        end
    end

endmodule

// ---- sim/fault_status_protect_monitor.sv ----
// Purpose: port checker for the fault status and write protect bank
// Assumes: one clock domain, asynchronous active low reset
// Notes:   bound to every instance of the bank
`timescale 1ns/1ps
`include "fault_status_consts.vh"

module fault_status_protect_monitor #(
    parameter NF = 4,
    parameter FW = 4
) (
    // clock and reset
    input logic          clk,
    input logic          rst_b,
    // register port
    input logic [7:0]    addr,
    input logic [31:0]   wdata,
    input logic          wr,
    input logic          rd,
    input logic [31:0]   rdata,
    // pins and status
    input logic [NF-1:0] fault_pin,
    input logic          write_protect_on,
    input logic          fault_summary_flag,
    input logic          irq
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    ////////////////////////////////////////////////////////////
    rdata_idle_a: assert property (!rd |=> rdata == 32'h0000_0000)
        else $error("read data not zero outside a read");
    wp_read_a: assert property (rd && addr == `OFS_STATUS |=>
        rdata[6] == $past(write_protect_on)) else $error("protect bit read wrong");
    rsvd_zero_a: assert property (rd && addr == `OFS_STATUS |=>
        rdata[31:8] == 24'h00_0000 && rdata[4] == 1'b0) else $error("reserved bits set");
    summary_or_a: assert property (rd && addr == `OFS_STATUS |=>
        rdata[7] == |rdata[3:0]) else $error("summary not OR of flags");
    summary_port_a: assert property (rd && addr == `OFS_STATUS |=>
        rdata[7] == $past(fault_summary_flag)) else $error("summary port differs");
    wp_set_a: assert property (wr && addr == `OFS_STATUS && wdata[6] |=>
        write_protect_on) else $error("protect not set by write");
    wp_keep_a: assert property (wr && addr == `OFS_STATUS && !wdata[6] |=>
        $stable(write_protect_on)) else $error("protect changed by zero write");
    wp_clear_a: assert property ($fell(write_protect_on) |->
        $past(wr && addr == `OFS_MODE && wdata[2])) else $error("protect cleared wrongly");
    flag_cause_a: assert property ($rose(fault_summary_flag) |->
        $past(fault_pin, 3) != 0) else $error("flag set without a fault");
    flag_clear_a: assert property ($fell(fault_summary_flag) |->
        $past(wr && addr == `OFS_STATUS)) else $error("flag cleared without a write");
    irq_drop_a: assert property ($fell(irq) |-> $past(rd || wr) || $past(rd || wr, 2))
        else $error("interrupt dropped without an access");
endmodule

bind fault_status_protect fault_status_protect_monitor #(.NF(NF), .FW(FW)) mon (
    .clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .fault_pin(fault_pin), .write_protect_on(write_protect_on),
    .fault_summary_flag(fault_summary_flag), .irq(irq));

// ---- sim/fault_pin_src.sv ----
// Purpose: fault pin source standing in for the outside world
// Assumes: pins are active high levels, asynchronous to clk
// Notes:   slow adds about two cycles of lag
`timescale 1ns/1ps

module fault_pin_src (
    // clock
    input  logic       clk,
    // requested level
    input  logic [3:0] want,
    input  logic       slow,
    // pins
    output reg   [3:0] pin
);
    initial pin = 4'h0;
    always @(posedge clk) begin
        pin <= #(slow ? 23 : 3) want;
    end
endmodule

// ---- sim/testbench.sv ----
// Purpose: self checking bench of the fault status and write protect bank
// Assumes: register port with read data one cycle after the strobe
// Notes:   expected status built from a small model of flags and protect
`timescale 1ns/1ps
`include "fault_status_consts.vh"

module testbench;
    logic        clk, rst_b, wr, rd, slow, irq, wpo, sum, wp, fen;
    logic [7:0]  addr;
    logic [31:0] wdata, rdata, d, r;
    logic [3:0]  want, pin, fl, en;
    integer      n_errors, num_checks, seed, i;

    fault_status_protect #(.NF(4), .FW(4)) dut (.clk(clk), .rst_b(rst_b),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .fault_pin(pin), .write_protect_on(wpo), .fault_summary_flag(sum), .irq(irq));
    fault_pin_src src (.clk(clk), .want(want), .slow(slow), .pin(pin));

    ////////////////////////////////////////////////////////////
    function [31:0] expst;
        expst = {24'h00_0000, |fl, wp, fen & |(want & en), 1'b0, fl};
    endfunction
    task chk(input [31:0] g, input [31:0] e);
        num_checks = num_checks + 1;
        if (g !== e) begin
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
            n_errors = n_errors + 1;
        end
    endtask
    task wr_reg(input [7:0] a, input [31:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task rd_reg(input [7:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    task rd_chk(input [7:0] a, input [31:0] e);
        rd_reg(a);
        chk(d, e);
        chk({30'h0000_0000, sum, wpo}, {30'h0000_0000, |fl, wp});
    endtask
    task settle;
        repeat (10) @(posedge clk);
    endtask
    task irq_chk(input e);
        repeat (2) @(posedge clk);
        #1 chk({31'h0000_0000, irq}, {31'h0000_0000, e});
    endtask
    task final_report;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #200000;
        n_errors = n_errors + 1;
        final_report;
    end
    initial begin
        rst_b = 1'b0; addr = 8'h00; wdata = 32'h0000_0000; wr = 1'b0; rd = 1'b0;
        want = 4'h0; slow = 1'b0; wp = 1'b1; fl = 4'h0; fen = 1'b0; en = 4'h0;
        n_errors = 0; num_checks = 0; seed = 25636;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        rd_chk(`OFS_STATUS, expst());
        rd_chk(`OFS_MODE, 32'h0000_0000);
        wr_reg(`OFS_FCTRL, 32'h0000_00FF);
        en = 4'hF;
        rd_chk(`OFS_FCTRL, 32'h0000_000F);
        want <= 4'h3;
        settle;
        rd_chk(`OFS_STATUS, expst());
        want <= 4'h0;
        settle;
        wr_reg(`OFS_IRQ_MASK, 32'h0000_00FF);
        wr_reg(`OFS_MODE, 32'h0000_0005);
        rd_chk(`OFS_STATUS, expst());
        wr_reg(`OFS_MODE, 32'h0000_0005);
        wp = 1'b0;
        fen = 1'b1;
        rd_chk(`OFS_MODE, 32'h0000_0005);
        rd_chk(`OFS_STATUS, expst());
        wr_reg(`OFS_FCTRL, 32'h0000_00FF);
        rd_chk(`OFS_FCTRL, 32'h0000_00FF);
        wr_reg(`OFS_STATUS, 32'h0000_0000);
        rd_chk(`OFS_STATUS, expst());
        wr_reg(`OFS_STATUS, 32'h0000_0040);
        wp = 1'b1;
        rd_chk(`OFS_STATUS, expst());
        rd_chk(`OFS_MODE, 32'h0000_0001);
        want <= 4'h1;
        settle;
        fl = 4'h1;
        rd_chk(`OFS_STATUS, expst());
        irq_chk(1'b1);
        rd_chk(`OFS_IRQ_STAT, 32'h0000_0001);
        irq_chk(1'b0);
        wr_reg(`OFS_IRQ_MASK, 32'h0000_0000);
        want <= 4'h3;
        settle;
        fl = 4'h3;
        irq_chk(1'b0);
        wr_reg(`OFS_IRQ_MASK, 32'h0000_00FF);
        irq_chk(1'b1);
        rd_chk(`OFS_IRQ_STAT, 32'h0000_0002);
        rd_chk(`OFS_STATUS, expst());
        wr_reg(`OFS_STATUS, 32'h0000_0000);
        rd_chk(`OFS_STATUS, expst());
        wr_reg(`OFS_STATUS, 32'h0000_00FF);
        rd_chk(`OFS_STATUS, expst());
        want <= 4'h2;
        settle;
        rd_reg(`OFS_STATUS);
        wr_reg(`OFS_STATUS, 32'h0000_00CE);
        fl = 4'h2;
        rd_chk(`OFS_STATUS, expst());
        want <= 4'h0;
        settle;
        rd_reg(`OFS_STATUS);
        want <= 4'h2;
        repeat (6) @(posedge clk);
        want <= 4'h0;
        settle;
        wr_reg(`OFS_STATUS, 32'h0000_00C0);
        rd_chk(`OFS_STATUS, expst());
        wr_reg(`OFS_STATUS, 32'h0000_004F);
        fl = 4'h0;
        rd_chk(`OFS_STATUS, expst());
        for (i = 0; i < 6; i = i + 1) begin
            r = $random(seed);
            want <= r[3:0];
            slow <= r[4];
            settle;
            fl = r[3:0];
            rd_chk(`OFS_STATUS, expst());
            want <= 4'h0;
            settle;
            rd_reg(`OFS_STATUS);
            wr_reg(`OFS_STATUS, 32'h0000_0040);
            fl = 4'h0;
            rd_chk(`OFS_STATUS, expst());
        end
        slow <= 1'b0;
        wr_reg(`OFS_FCTRL, 32'h0000_040F);
        rd_chk(`OFS_FCTRL, 32'h0000_04FF);
        want <= 4'h1;
        repeat (2) @(posedge clk);
        want <= 4'h0;
        settle;
        rd_chk(`OFS_STATUS, expst());
        want <= 4'h1;
        settle;
        fl = 4'h1;
        rd_chk(`OFS_STATUS, expst());
        want <= 4'h0;
        settle;
        rd_reg(`OFS_STATUS);
        wr_reg(`OFS_STATUS, 32'h0000_0040);
        fl = 4'h0;
        wr_reg(8'h20, 32'hFFFF_FFFF);
        rd_chk(8'h20, 32'h0000_0000);
        rd_chk(`OFS_STATUS, expst());
        final_report;
    end
endmodule
